// [fpod_checker.sv]
// Checker for decoded option outputs and APB answer timing
`include "fpod_defines.vh"
module fpod_checker (
    input logic        clk,
    input logic        srst,
    input logic        cfg_load,
    input logic [23:0] cfg_code_prot_word,
    input logic [23:0] cfg_dev_opt_word,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic        pslverr,
    input logic        alt_vector_table_off,
    input logic [1:0]  config_seg_protect_level,
    input logic        config_seg_write_protect,
    input logic [1:0]  general_seg_protect_level,
    input logic        general_seg_write_protect,
    input logic        boot_seg_absent,
    input logic [1:0]  boot_seg_protect_level,
    input logic        boot_seg_write_protect,
    input logic        second_spi_remap_select,
    input logic        pad_threshold_select,
    input logic        second_i2c_default_pins,
    input logic        first_i2c_default_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] c1, c2, o1, o2, s_c, s_o;
    logic        l1, l2, s_en;
    // All decoded outputs except cfg_valid in one vector
    wire  [14:0] outs = {alt_vector_table_off, config_seg_protect_level, config_seg_write_protect,
        general_seg_protect_level, general_seg_write_protect, boot_seg_absent, boot_seg_protect_level,
        boot_seg_write_protect, second_spi_remap_select, pad_threshold_select, second_i2c_default_pins,
        first_i2c_default_pins};
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Staged words and stage enable as written over the bus
    always @(posedge clk) begin
        if (srst) begin
            s_en <= 1'b0;
            s_c  <= 24'hFFFFFF;
            s_o  <= 24'hFFFFFF;
        end else if (psel && penable && pready && pwrite && !pslverr) begin
            if (paddr == `FPOD_OFF_CTRL) begin
                s_en <= pwdata[0];
            end
            if (paddr == `FPOD_OFF_STAGE_PROT) begin
                s_c <= pwdata[23:0];
            end
            if (paddr == `FPOD_OFF_STAGE_OPT) begin
                s_o <= pwdata[23:0];
            end
        end
    end
    // Words seen two edges back, with their load flag; staging only clears bits
    always @(posedge clk) begin
        c1 <= s_en ? (cfg_code_prot_word & s_c) : cfg_code_prot_word;
        c2 <= c1;
        o1 <= s_en ? (cfg_dev_opt_word & s_o) : cfg_dev_opt_word;
        o2 <= o1;
        l1 <= cfg_load && !srst;
        l2 <= l1 && !srst;
    end
    // Level code of a 3-bit field
    function automatic logic [1:0] lvl(input logic [2:0] f);
        return (f == 3'h7) ? `FPOD_LVL_NONE : (f == 3'h6) ? `FPOD_LVL_STANDARD : `FPOD_LVL_HIGH;
    endfunction
    a_alt_vec_decode: assert property (l2 |-> outs[14] == c2[15])
        else $error("alt vector output wrong");
    a_cfg_level_decode: assert property (l2 |-> outs[13:12] == lvl(c2[11:9]))
        else $error("config level wrong");
    a_gen_level_decode: assert property (l2 |-> outs[10:9] == lvl({1'b1, c2[7:6]}))
        else $error("general level wrong");
    a_boot_level_decode: assert property (l2 |-> outs[6:5] == lvl({1'b1, c2[2:1]}))
        else $error("boot level wrong");
    a_lock_decode: assert property (l2 |-> {outs[11], outs[8], outs[4]} == ~{c2[8], c2[5], c2[0]})
        else $error("write protect wrong");
    a_boot_absent: assert property (l2 |-> outs[7] == c2[3])
        else $error("boot absent wrong");
    a_option_pins: assert property (l2 |-> outs[3:0] == {o2[13], o2[10], o2[4], o2[3]})
        else $error("option outputs wrong");
    a_outputs_hold: assert property (!$past(cfg_load, 2) && !$past(cfg_load, 3) && !$past(srst)
        && !$past(srst, 2) |-> $stable(outs))
        else $error("outputs moved without load");
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_error_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    cover property (l2);
    cover property (pslverr);
    cover property (psel && penable && pready);
    cover property (cfg_load && s_en);
endmodule // fpod_checker

bind fpod_top fpod_checker u_fpod_checker (.clk, .srst, .cfg_load, .cfg_code_prot_word, .cfg_dev_opt_word,
    .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .alt_vector_table_off, .config_seg_protect_level,
    .config_seg_write_protect, .general_seg_protect_level, .general_seg_write_protect, .boot_seg_absent,
    .boot_seg_protect_level, .boot_seg_write_protect, .second_spi_remap_select, .pad_threshold_select,
    .second_i2c_default_pins, .first_i2c_default_pins);

// [fpod_defines.vh]
// Constants for the flash protection option decoder
`ifndef FPOD_DEFINES_VH
`define FPOD_DEFINES_VH

// Register byte offsets
`define FPOD_OFF_CODE_PROT      12'h000
`define FPOD_OFF_DEV_OPT        12'h004
`define FPOD_OFF_STATUS         12'h008
`define FPOD_OFF_CTRL           12'h00C
`define FPOD_OFF_STAGE_PROT     12'h010
`define FPOD_OFF_STAGE_OPT      12'h014

// Word width and masks of implemented or reserved bits
`define FPOD_WORD_W             24
`define FPOD_PROT_KEEP_MASK     24'h008FEF
`define FPOD_OPT_KEEP_MASK      24'h00279C
`define FPOD_OPT_RSVD_MASK      24'h000384
`define FPOD_WORD_ERASED        24'hFFFFFF

// Code protection word fields
`define FPOD_AIVT_BIT           15
`define FPOD_CSS_HI             11
`define FPOD_CSS_LO             9
`define FPOD_CONFIG_SEG_WRITE_LOCK_N_BIT           8
`define FPOD_GSS_HI             7
`define FPOD_GSS_LO             6
`define FPOD_GENERAL_SEG_WRITE_LOCK_N_BIT           5
`define FPOD_BOOT_SEG_ABSENT_BIT           3
`define FPOD_BSS_HI             2
`define FPOD_BSS_LO             1
`define FPOD_BOOT_SEG_WRITE_LOCK_N_BIT           0

// Device option word fields
`define FPOD_SPI_SEL_BIT        13
`define FPOD_SMB_BIT            10
`define FPOD_I2C2_BIT           4
`define FPOD_I2C1_BIT           3

// Decoded protection levels
`define FPOD_LVL_NONE           2'h0
`define FPOD_LVL_STANDARD       2'h1
`define FPOD_LVL_HIGH           2'h2

// Control register fields
`define FPOD_CTRL_STAGE_EN_BIT  0
`define FPOD_CTRL_RESET         32'h00000000

`endif

// [fpod_level_decode.v]
// Protection level decoder for one segment level field
`include "fpod_defines.vh"

module fpod_level_decode #(
    parameter W = 2
) (
    input  wire [W-1:0] level_field,
    output reg  [1:0]   level
);
    // All ones: none; all ones but bit 0: standard; else high
    always @* begin
        if (level_field == {W{1'b1}}) begin
            level = `FPOD_LVL_NONE;
        end else if (level_field == {{(W-1){1'b1}}, 1'b0}) begin
            level = `FPOD_LVL_STANDARD;
        end else begin
            level = `FPOD_LVL_HIGH;
        end
    end
endmodule // fpod_level_decode

// [fpod_tb.sv]
// Self-checking bench for the flash protection option decoder
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [23:0] c, o; logic [14:0] e;} fpod_row_t;
    logic        clk = 0, srst = 1, cfg_load = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic        cfg_valid;
    logic [23:0] cw = 24'hFFFFFF, ow = 24'hFFFFFF;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    wire  [14:0] dec;
    int          n_mismatch = 0, total_checks = 0;
    // Words in, decoded outputs expected
    fpod_row_t   rows [5] = '{
        '{24'hFFFFFF, 24'hFFFFFF, 15'b1_00_0_00_0_1_00_0_1111},
        '{24'h000000, 24'h000384, 15'b0_10_1_10_1_0_10_1_0000},
        '{24'hFFFD9C, 24'hFFFBEF, 15'b1_01_0_01_1_1_01_1_1001},
        '{24'hFF7A73, 24'hFFDFF7, 15'b0_10_1_10_0_0_10_0_0110},
        '{24'hFFF9FF, 24'hFFFFFF, 15'b1_10_0_00_0_1_00_0_1111}};

    fpod_top dut (.clk(clk), .srst(srst), .cfg_load(cfg_load), .cfg_code_prot_word(cw), .cfg_dev_opt_word(ow),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_valid(cfg_valid), .alt_vector_table_off(dec[14]),
        .config_seg_protect_level(dec[13:12]), .config_seg_write_protect(dec[11]),
        .general_seg_protect_level(dec[10:9]), .general_seg_write_protect(dec[8]), .boot_seg_absent(dec[7]),
        .boot_seg_protect_level(dec[6:5]), .boot_seg_write_protect(dec[4]), .second_spi_remap_select(dec[3]),
        .pad_threshold_select(dec[2]), .second_i2c_default_pins(dec[1]), .first_i2c_default_pins(dec[0]));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // Compare a register or flag value
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Compare the decoded output vector
    task chk_dec(input logic [14:0] e);
        chk("decoded outputs", {17'h00000, e}, {17'h00000, dec});
    endtask

    // One APB transfer, held until ready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Load both words, then move the flash inputs away
    task load(input logic [23:0] c, input logic [23:0] o);
        @(posedge clk);
        cfg_load <= 1'b1;
        cw <= c;
        ow <= o;
        @(posedge clk);
        cfg_load <= 1'b0;
        cw <= ~c;
        ow <= ~o;
        repeat (3) @(posedge clk);
    endtask

    // Counts and verdict
    task report_and_stop;
        $display("Mismatches %0d of %0d checks", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk_dec(rows[0].e);
        chk("cfg_valid", 32'h00000000, {31'h0, cfg_valid});
        apb(1'b0, 12'h000, 32'h00000000);
        chk("code reset", 32'h00FFFFFF, rd);
        foreach (rows[i]) begin
            load(rows[i].c, rows[i].o);
            chk_dec(rows[i].e);
            chk("cfg_valid", 32'h00000001, {31'h0, cfg_valid});
            apb(1'b0, 12'h000, 32'h00000000);
            chk("code readback", {8'h00, rows[i].c | 24'hFF7010}, rd);
            apb(1'b0, 12'h004, 32'h00000000);
            chk("option readback", {8'h00, rows[i].o | 24'hFFDBE7}, rd);
            chk_dec(rows[i].e);
        end
        // Unmapped read, write to a read-only word, status read
        apb(1'b0, 12'h018, 32'h00000000);
        chk("unmapped error", 32'h00000001, {31'h0, err});
        chk("unmapped data", 32'h00000000, rd);
        apb(1'b1, 12'h000, 32'h00000000);
        apb(1'b0, 12'h000, 32'h00000000);
        chk("read-only word", 32'h00FFF9FF, rd);
        apb(1'b0, 12'h008, 32'h00000000);
        chk("status", 32'h00000505, rd);
        // Staged words clear bits of the next load
        apb(1'b1, 12'h010, 32'h00FF7FFE);
        apb(1'b1, 12'h014, 32'h00FFFFE7);
        apb(1'b1, 12'h00C, 32'h00000001);
        apb(1'b0, 12'h00C, 32'h00000000);
        chk("ctrl", 32'h00000001, rd);
        load(24'hFFFFFF, 24'hFFFFFF);
        chk_dec(15'b0_00_0_00_0_1_00_1_1100);
        apb(1'b0, 12'h000, 32'h00000000);
        chk("staged code", 32'h00FF7FFE, rd);
        apb(1'b1, 12'h00C, 32'h00000000);
        // Reset in mid-run restores erased decode
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk_dec(rows[0].e);
        chk("cfg_valid", 32'h00000000, {31'h0, cfg_valid});
        report_and_stop;
    end

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule // tb

// [fpod_top.v]
// Flash protection option decoder with APB register access
//
// The register offsets and the APB slave port were decided locally.
`include "fpod_defines.vh"

module fpod_top (
    input  wire        clk,
    input  wire        srst,
    // Configuration load from flash
    input  wire        cfg_load,
    input  wire [23:0] cfg_code_prot_word,
    input  wire [23:0] cfg_dev_opt_word,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Decoded controls
    output reg         cfg_valid,
    output reg         alt_vector_table_off,
    output reg  [1:0]  config_seg_protect_level,
    output reg         config_seg_write_protect,
    output reg  [1:0]  general_seg_protect_level,
    output reg         general_seg_write_protect,
    output reg         boot_seg_absent,
    output reg  [1:0]  boot_seg_protect_level,
    output reg         boot_seg_write_protect,
    output reg         second_spi_remap_select,
    output reg         pad_threshold_select,
    output reg         second_i2c_default_pins,
    output reg         first_i2c_default_pins
);
    // Latched words
    wire [23:0] code_protection_config;
    wire [23:0] device_option_config;

    // Software staging state and load tracking
    reg  [31:0] ctrl;
    reg  [23:0] stage_prot;
    reg  [23:0] stage_opt;
    reg         load_seen;
    reg  [7:0]  load_count;

    // Decoder outputs
    wire [1:0]  css_level;
    wire [1:0]  gss_level;
    wire [1:0]  bss_level;

    // APB phase decode
    wire        apb_setup;
    wire        apb_access;
    wire        apb_wr;
    wire        addr_hit;
    reg  [31:0] next_prdata;
    reg         next_slverr;
    wire        stage_en;

    assign apb_setup  = psel & ~penable;
    assign apb_access = psel & penable & pready;
    assign apb_wr     = apb_access & pwrite & ~pslverr;
    assign stage_en   = ctrl[`FPOD_CTRL_STAGE_EN_BIT];

    // Known register offsets
    assign addr_hit = (paddr == `FPOD_OFF_CODE_PROT)  |
                      (paddr == `FPOD_OFF_DEV_OPT)    |
                      (paddr == `FPOD_OFF_STATUS)     |
                      (paddr == `FPOD_OFF_CTRL)       |
                      (paddr == `FPOD_OFF_STAGE_PROT) |
                      (paddr == `FPOD_OFF_STAGE_OPT);

    // Code protection word shadow
    fpod_word_shadow #(
        .KEEP_MASK (`FPOD_PROT_KEEP_MASK),
        .FORCE_ONE (24'h000000)
    ) u_prot_shadow (
        .clk        (clk),
        .srst       (srst),
        .load       (cfg_load),
        .flash_word (cfg_code_prot_word),
        .stage_word (stage_prot),
        .stage_en   (stage_en),
        .word       (code_protection_config)
    );

    // Device option word shadow; reserved bits forced high
    fpod_word_shadow #(
        .KEEP_MASK (`FPOD_OPT_KEEP_MASK),
        .FORCE_ONE (`FPOD_OPT_RSVD_MASK)
    ) u_opt_shadow (
        .clk        (clk),
        .srst       (srst),
        .load       (cfg_load),
        .flash_word (cfg_dev_opt_word),
        .stage_word (stage_opt),
        .stage_en   (stage_en),
        .word       (device_option_config)
    );

    // Segment level decoders
    fpod_level_decode #(
        .W (3)
    ) u_css_dec (
        .level_field (code_protection_config[`FPOD_CSS_HI:`FPOD_CSS_LO]),
        .level       (css_level)
    );

    fpod_level_decode #(
        .W (2)
    ) u_gss_dec (
        .level_field (code_protection_config[`FPOD_GSS_HI:`FPOD_GSS_LO]),
        .level       (gss_level)
    );

    fpod_level_decode #(
        .W (2)
    ) u_bss_dec (
        .level_field (code_protection_config[`FPOD_BSS_HI:`FPOD_BSS_LO]),
        .level       (bss_level)
    );

    // Load tracking for status
    always @(posedge clk) begin
        if (srst) begin
            load_seen  <= 1'b0;
            load_count <= 8'h00;
        end else if (cfg_load) begin
            load_seen  <= 1'b1;
            load_count <= load_count + 8'h01;
        end
    end

    // Decoded outputs follow the held words only; cfg_valid follows load_seen
    always @(posedge clk) begin
        if (srst) begin
            cfg_valid                 <= 1'b0;
            alt_vector_table_off      <= 1'b1;
            config_seg_protect_level  <= `FPOD_LVL_NONE;
            config_seg_write_protect  <= 1'b0;
            general_seg_protect_level <= `FPOD_LVL_NONE;
            general_seg_write_protect <= 1'b0;
            boot_seg_absent           <= 1'b1;
            boot_seg_protect_level    <= `FPOD_LVL_NONE;
            boot_seg_write_protect    <= 1'b0;
            second_spi_remap_select   <= 1'b1;
            pad_threshold_select      <= 1'b1;
            second_i2c_default_pins   <= 1'b1;
            first_i2c_default_pins    <= 1'b1;
        end else begin
            cfg_valid                 <= load_seen;
            alt_vector_table_off      <= code_protection_config[`FPOD_AIVT_BIT];
            config_seg_protect_level  <= css_level;
            config_seg_write_protect  <= ~code_protection_config[`FPOD_CONFIG_SEG_WRITE_LOCK_N_BIT];
            general_seg_protect_level <= gss_level;
            general_seg_write_protect <= ~code_protection_config[`FPOD_GENERAL_SEG_WRITE_LOCK_N_BIT];
            boot_seg_absent           <= code_protection_config[`FPOD_BOOT_SEG_ABSENT_BIT];
            boot_seg_protect_level    <= bss_level;
            boot_seg_write_protect    <= ~code_protection_config[`FPOD_BOOT_SEG_WRITE_LOCK_N_BIT];
            second_spi_remap_select   <= device_option_config[`FPOD_SPI_SEL_BIT];
            pad_threshold_select      <= device_option_config[`FPOD_SMB_BIT];
            second_i2c_default_pins   <= device_option_config[`FPOD_I2C2_BIT];
            first_i2c_default_pins    <= device_option_config[`FPOD_I2C1_BIT];
        end
    end

    // Software writable registers
    always @(posedge clk) begin
        if (srst) begin
            ctrl       <= `FPOD_CTRL_RESET;
            stage_prot <= `FPOD_WORD_ERASED;
            stage_opt  <= `FPOD_WORD_ERASED;
        end else if (apb_wr) begin
            case (paddr)
                `FPOD_OFF_CTRL: begin
                    ctrl <= {31'h00000000, pwdata[`FPOD_CTRL_STAGE_EN_BIT]};
                end
                `FPOD_OFF_STAGE_PROT: begin
                    stage_prot <= pwdata[23:0];
                end
                `FPOD_OFF_STAGE_OPT: begin
                    // Reserved bits kept at one regardless of software
                    stage_opt <= pwdata[23:0] | `FPOD_OPT_RSVD_MASK;
                end
                default: begin
                    ctrl <= ctrl;
                end
            endcase
        end
    end

    // Read data selection for the setup cycle
    always @* begin
        next_prdata = 32'h00000000;
        next_slverr = ~addr_hit;
        case (paddr)
            `FPOD_OFF_CODE_PROT: begin
                next_prdata = {8'h00, code_protection_config};
            end
            `FPOD_OFF_DEV_OPT: begin
                next_prdata = {8'h00, device_option_config};
            end
            `FPOD_OFF_STATUS: begin
                next_prdata = {16'h0000, load_count, 1'b0, bss_level,
                               gss_level, css_level, load_seen};
            end
            `FPOD_OFF_CTRL: begin
                next_prdata = ctrl;
            end
            `FPOD_OFF_STAGE_PROT: begin
                next_prdata = {8'h00, stage_prot};
            end
            `FPOD_OFF_STAGE_OPT: begin
                next_prdata = {8'h00, stage_opt};
            end
            default: begin
                next_prdata = 32'h00000000;
            end
        endcase
    end

    // APB answer: ready in the first access cycle
    always @(posedge clk) begin
        if (srst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
            pready  <= 1'b1;
            pslverr <= next_slverr;
        end else begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // fpod_top

// [fpod_word_shadow.v]
// Shadow of one 24-bit configuration word, loaded at config load
`include "fpod_defines.vh"

module fpod_word_shadow #(
    parameter [23:0] KEEP_MASK = 24'h000000,
    parameter [23:0] FORCE_ONE = 24'h000000
) (
    input  wire        clk,
    input  wire        srst,
    input  wire        load,
    input  wire [23:0] flash_word,
    input  wire [23:0] stage_word,
    input  wire        stage_en,
    output wire [23:0] word
);
    reg  [23:0] held;
    wire [23:0] merged;

    // Staged value can only clear bits, as program-once cells do
    assign merged = stage_en ? (flash_word & stage_word) : flash_word;

    // Erased at reset, capture only at load, hold otherwise
    always @(posedge clk) begin
        if (srst) begin
            held <= `FPOD_WORD_ERASED;
        end else if (load) begin
            held <= (merged & KEEP_MASK) | ~KEEP_MASK | FORCE_ONE;
        end
    end

    assign word = held;
endmodule // fpod_word_shadow
